// file: src/sia_top.v
// sia_top.v: sensor input data aligner, pixel port to 16-bit pixel bus
// assumes pixel clock and data pins are asynchronous to clk_i
// Function
// [R1] raw data shifted up by shift select n, low n bits zero-filled
// [R2] board wires narrow raw sensors to upper or lower lines, unused tied low
// [R3] 16-bit raw: upper port is bits 15..8, lower port bits 7..0
// [R4] 16-bit YCbCr luma from upper port; 8-bit with swap set uses upper
// [R5] 8-bit YCbCr with swap clear takes byte stream from lower port
// [R6] raw widths 8 to 16 bits and YCbCr 8 or 16 bits accepted
// [R7] pin function select resets to zero, pins assigned to video
// [R8] software clears low 16 pin select bits before capture
// [R9] polarity bit inverts every incoming data bit
// [R10] clock edge invert bit selects rising or falling sample edge
// [R11] one word per active pixel edge, output with valid
// [R12] shift select above range behaves as largest shift; the code keeps write bits 2..0 only, so values of 8 and up wrap modulo 8
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sia_defs.vh"
module sia_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // register port
  input  wire [7:0]  reg_addr_i,
  input  wire [31:0] reg_wdata_i,
  input  wire        reg_wr_i,
  input  wire        reg_rd_i,
  output reg  [31:0] reg_rdata_o,
  // sensor pins
  input  wire        pix_clk_i,
  input  wire [7:0]  upper_input_port_i,
  input  wire [7:0]  lower_input_port_i,
  // aligned pixel stream
  output reg  [15:0] pix_data_o,
  output reg         pix_valid_o,
  input  wire        pix_ready_i,
  // status
  output reg         video_pins_o,
  output reg         overflow_o
);
  // control state
  reg  [7:0]  ctrl_q;
  reg  [2:0]  input_shift_select_q;
  reg  [31:0] pin_function_select_q;
  reg         ovf_q;
  reg  [15:0] cap_cnt_q;
  // pin synchronisers
  reg  [2:0]  pclk_s_q;
  reg  [7:0]  up_s1_q;
  reg  [7:0]  up_s2_q;
  reg  [7:0]  lo_s1_q;
  reg  [7:0]  lo_s2_q;
  // alignment stage
  reg  [15:0] algn_q;
  reg         algn_v_q;
  reg  [15:0] algn_d;
  // fifo wiring
  wire        f_in_ready;
  wire        f_out_valid;
  wire [15:0] f_out_data;
  wire        f_out_ready;
  wire        edge_hit;
  wire        rise;
  wire        fall;
  wire [1:0]  fmt;
  wire        luma_chroma_port_swap;
  wire        data_polarity_invert;
  wire        pixel_clock_edge_invert;
  wire        cap_en;
  wire [15:0] raw_in;

  assign fmt                     = ctrl_q[`SIA_CTRL_FMT_HI:`SIA_CTRL_FMT_LO];
  assign luma_chroma_port_swap   = ctrl_q[`SIA_CTRL_SWAP];
  assign data_polarity_invert    = ctrl_q[`SIA_CTRL_DATA_POLARITY_INVERT];
  assign pixel_clock_edge_invert = ctrl_q[`SIA_CTRL_PIXEL_CLOCK_EDGE_INVERT];
  // capture needs enable and the video pin function selected
  assign cap_en = ctrl_q[`SIA_CTRL_EN] & ((pin_function_select_q & `SIA_PINSEL_VID_MASK) == 32'h00000000);

  // left-align with zero fill; all eight 3-bit codes are plain shifts of 0 to 7, none reserved
  function [15:0] sia_align;
    input [15:0] din;
    input [2:0]  n;
    begin
      sia_align = din << n; // R1 R12
    end
  endfunction

  // two-flop synchronisers, pixel clock gets a third stage for edge detect
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pclk_s_q <= 3'h0;
      up_s1_q  <= 8'h00;
      up_s2_q  <= 8'h00;
      lo_s1_q  <= 8'h00;
      lo_s2_q  <= 8'h00;
    end else begin
      pclk_s_q <= {pclk_s_q[1:0], pix_clk_i};
      up_s1_q  <= upper_input_port_i;
      up_s2_q  <= up_s1_q;
      lo_s1_q  <= lower_input_port_i;
      lo_s2_q  <= lo_s1_q;
    end
  end

  // edge select on synchronised pixel clock
  assign rise     = pclk_s_q[1] & ~pclk_s_q[2];
  assign fall     = ~pclk_s_q[1] & pclk_s_q[2];
  assign edge_hit = pixel_clock_edge_invert ? fall : rise; // R10

  // port mapping and polarity
  assign raw_in = {up_s2_q, lo_s2_q} ^ {16{data_polarity_invert}}; // R3 R9

  // format-dependent mapping onto the internal bus
  always @* begin
    algn_d = raw_in;
    case (fmt)
      `SIA_FMT_RAW: begin
        algn_d = sia_align(raw_in, input_shift_select_q); // R1 R6
      end
      `SIA_FMT_YC16: begin
        algn_d = raw_in; // R4
      end
      `SIA_FMT_YC8: begin
        if (luma_chroma_port_swap) begin
          algn_d = {raw_in[15:8], 8'h00}; // R4
        end else begin
          algn_d = {raw_in[7:0], 8'h00}; // R5
        end
      end
      default: begin
        algn_d = raw_in;
      end
    endcase
  end

  // capture one word per selected pixel edge
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      algn_q   <= 16'h0000;
      algn_v_q <= 1'b0;
    end else begin
      algn_v_q <= edge_hit & cap_en; // R11
      if (edge_hit) begin
        algn_q <= algn_d;
      end
    end
  end

  sia_fifo #(
    .WIDTH (`SIA_FIFO_W),
    .DEPTH (`SIA_FIFO_D),
    .AW    (`SIA_FIFO_AW)
  ) u_fifo (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (algn_v_q),
    .in_ready_o  (f_in_ready),
    .in_data_i   (algn_q),
    .out_valid_o (f_out_valid),
    .out_ready_i (f_out_ready),
    .out_data_o  (f_out_data)
  );

  // output register stage, loads when empty or consumed
  assign f_out_ready = ~pix_valid_o | pix_ready_i;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      pix_data_o  <= 16'h0000;
      pix_valid_o <= 1'b0;
    end else if (f_out_ready) begin
      pix_valid_o <= f_out_valid; // R11
      if (f_out_valid) begin
        pix_data_o <= f_out_data;
      end
    end
  end

  // register writes, overflow sticky with set over clear
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q                <= `SIA_CTRL_RST;
      input_shift_select_q  <= `SIA_SHIFT_RST;
      pin_function_select_q <= `SIA_PINSEL_RST; // R7
      ovf_q                 <= 1'b0;
      cap_cnt_q             <= 16'h0000;
    end else begin
      if (reg_wr_i && reg_addr_i == `SIA_REG_CTRL) begin
        ctrl_q <= reg_wdata_i[7:0];
      end
      if (reg_wr_i && reg_addr_i == `SIA_REG_SHIFT) begin
        input_shift_select_q <= reg_wdata_i[2:0];
      end
      if (reg_wr_i && reg_addr_i == `SIA_REG_PINSEL) begin
        pin_function_select_q <= reg_wdata_i; // R8
      end
      if (algn_v_q && !f_in_ready) begin
        ovf_q <= 1'b1;
      end else if (reg_wr_i && reg_addr_i == `SIA_REG_STATUS && reg_wdata_i[0]) begin
        ovf_q <= 1'b0;
      end
      if (algn_v_q && f_in_ready) begin
        cap_cnt_q <= cap_cnt_q + 16'h0001;
      end
    end
  end

  // register reads, one cycle latency, unmapped reads zero
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h00000000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SIA_REG_CTRL:   reg_rdata_o <= {24'h000000, ctrl_q};
        `SIA_REG_SHIFT:  reg_rdata_o <= {29'h00000000, input_shift_select_q};
        `SIA_REG_PINSEL: reg_rdata_o <= pin_function_select_q;
        `SIA_REG_STATUS: reg_rdata_o <= {cap_cnt_q, 13'h0000, f_out_valid, f_in_ready, ovf_q};
        `SIA_REG_DATA:   reg_rdata_o <= {16'h0000, algn_q};
        default:         reg_rdata_o <= 32'h00000000;
      endcase
    end else begin
      reg_rdata_o <= 32'h00000000;
    end
  end

  // status outputs
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      video_pins_o <= 1'b1;
      overflow_o   <= 1'b0;
    end else begin
      video_pins_o <= ((pin_function_select_q & `SIA_PINSEL_VID_MASK) == 32'h00000000);
      overflow_o   <= ovf_q;
    end
  end
endmodule
`default_nettype wire

// file: src/sia_defs.vh
// sia_defs.vh: constants for the sensor input data aligner
// assumes inclusion by bare name from src/ modules
`ifndef SIA_DEFS_VH
`define SIA_DEFS_VH

// register map (word per register, byte address)
`define SIA_ADDR_W          8
`define SIA_REG_CTRL        8'h00
`define SIA_REG_SHIFT       8'h04
`define SIA_REG_PINSEL      8'h08
`define SIA_REG_STATUS      8'h0C
`define SIA_REG_DATA        8'h10

// control register fields
`define SIA_CTRL_EN         0
`define SIA_CTRL_FMT_LO     1
`define SIA_CTRL_FMT_HI     2
`define SIA_CTRL_SWAP       3
`define SIA_CTRL_DATA_POLARITY_INVERT       4
`define SIA_CTRL_PIXEL_CLOCK_EDGE_INVERT   5
`define SIA_CTRL_RST        8'h00

// input formats
`define SIA_FMT_RAW         2'h0
`define SIA_FMT_YC16        2'h1
`define SIA_FMT_YC8         2'h2

// shift select
`define SIA_SHIFT_MAX       3'h7
`define SIA_SHIFT_RST       3'h0

// pin function select
`define SIA_PINSEL_RST      32'h00000000
`define SIA_PINSEL_VID_MASK 32'h0000FFFF

// fifo
`define SIA_FIFO_W          16
`define SIA_FIFO_D          32
`define SIA_FIFO_AW         5

`endif

// file: src/sia_fifo.v
// sia_fifo.v: synchronous fifo with valid/ready on both sides
// assumes a single clock and synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module sia_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // clock and reset
  input  wire             clk_i,
  input  wire             sys_rst_i,
  // fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0]    wr_q;
  reg [AW-1:0]    rd_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // storage write
  always @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // pointers and fill count
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_q  <= {AW{1'b0}};
      rd_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/sia_checker.sv
// sia_checker.sv: port assertions for the aligner top
// assumes a bind to sia_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module sia_checker (
  // watched ports
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [7:0]  reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic        reg_wr_i,
  input wire logic        reg_rd_i,
  input wire logic [31:0] reg_rdata_o,
  input wire logic [15:0] pix_data_o,
  input wire logic        pix_valid_o,
  input wire logic        pix_ready_i,
  input wire logic        video_pins_o,
  input wire logic        overflow_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic pin_ok_q;
  logic pin_wr_q;
  // shadow of the pin select state
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_ok_q <= 1'b1;
      pin_wr_q <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == 8'h08) begin
      pin_ok_q <= reg_wdata_i[15:0] == 16'h0;
      pin_wr_q <= 1'b1;
    end
  end
  sequence no_clr_s;
    !(reg_wr_i && reg_addr_i == 8'h0C && reg_wdata_i[0]);
  endsequence
  sequence wr_rd_s(a);
    reg_wr_i && reg_addr_i == a ##1 reg_rd_i && reg_addr_i == a;
  endsequence
  rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
    else $error("read data outside its slot");
  pinsel_reset_a: assert property (!pin_wr_q && reg_rd_i && reg_addr_i == 8'h08 |=> reg_rdata_o == 32'h0)
    else $error("pin select not zero after reset");
  pin_gate_a: assert property (pin_ok_q == $past(pin_ok_q) |-> video_pins_o == pin_ok_q)
    else $error("video pin flag wrong");
  valid_hold_a: assert property (pix_valid_o && !pix_ready_i |=> pix_valid_o)
    else $error("valid dropped without ready");
  data_hold_a: assert property (pix_valid_o && !pix_ready_i |=> $stable(pix_data_o))
    else $error("data moved while stalled");
  ovf_sticky_a: assert property (no_clr_s ##1 overflow_o ##0 no_clr_s ##1 no_clr_s |=> overflow_o)
    else $error("overflow lost without clear");
  shift_back_a: assert property (wr_rd_s(8'h04) |=> reg_rdata_o[2:0] == $past(reg_wdata_i[2:0], 2))
    else $error("shift select readback wrong");
  ctrl_back_a: assert property (wr_rd_s(8'h00) |=> reg_rdata_o[5:0] == $past(reg_wdata_i[5:0], 2))
    else $error("control readback wrong");
endmodule
`default_nettype wire

// file: tb/sia_sensor.sv
// sia_sensor.sv: behavioural image sensor on the pixel port
// assumes the bench calls its tasks; clock stands still between frames
`timescale 1ns/1ps
`default_nettype none
module sia_sensor (
  // pixel pins
  output logic       pix_clk_o,
  output logic [7:0] up_o,
  output logic [7:0] lo_o,
  // edge choice
  input wire logic   inv_i
);
  // idle level makes the first toggle the sampled one
  initial begin
    pix_clk_o = 1'b0;
    up_o = 8'h00;
    lo_o = 8'h00;
  end
  task automatic idle();
    pix_clk_o = inv_i;
  endtask
  // one word, held 4 system clocks either side of the sampled edge
  // pins move 10 ns off the system clock edge so they never race it
  task automatic send(input logic [15:0] w);
    #10 {up_o, lo_o} = w;
    #160 pix_clk_o = ~pix_clk_o;
    #140 pix_clk_o = ~pix_clk_o;
    #10;
  endtask
  // released lines show the inverse of the last word
  task automatic stop();
    #10 {up_o, lo_o} = ~{up_o, lo_o};
  endtask
endmodule
`default_nettype wire

// file: tb/tb_sia_top.sv
// tb_sia_top.sv: self-checking bench for the aligner
// assumes sia_top, sia_checker and sia_sensor compiled before
`timescale 1ns/1ps
`default_nettype none
module tb_sia_top;
  logic        clk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  logic [7:0]  reg_addr_i = 0, up, lo;
  logic [31:0] reg_wdata_i = 0, reg_rdata_o;
  logic        pix_clk, pix_valid_o, pix_ready_i = 0, video_pins_o, overflow_o;
  logic [15:0] pix_data_o, q[$];
  logic [1:0]  fmt = 0;
  logic [2:0]  sh = 0;
  logic        swap = 0, pol = 0, inv = 0, hold = 0, chk = 1;
  integer      seed = 32'h8E94, failures = 0, checked = 0, cyc = 0;
  sia_top dut (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .pix_clk_i(pix_clk), .upper_input_port_i(up), .lower_input_port_i(lo),
    .pix_data_o, .pix_valid_o, .pix_ready_i, .video_pins_o, .overflow_o);
  sia_sensor sen (.pix_clk_o(pix_clk), .up_o(up), .lo_o(lo), .inv_i(inv));
  always #20 clk_i = ~clk_i;
  task wrap_up();
    if (failures == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task cmp(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("BAD %0t seen %h want %h", $time, s, e);
    end
  endtask
  // hang guard and random downstream stalls
  always @(posedge clk_i) begin
    cyc++;
    pix_ready_i <= !hold && ($random(seed) & 3) != 0;
    if (cyc == 20000) begin
      failures++;
      wrap_up();
    end
  end
  // every accepted word must be the next expected one while chk is set
  always @(posedge clk_i)
    if (!sys_rst_i && chk && pix_valid_o && pix_ready_i) begin
      if (q.size() != 0) cmp(pix_data_o, q.pop_front());
      else cmp(32'h1, 32'h0);
    end
  function logic [15:0] exp_w(input logic [15:0] w);
    logic [15:0] v;
    v = pol ? ~w : w;
    if (fmt == 2'h0) return v << sh;
    if (fmt == 2'h1) return v;
    return {swap ? v[15:8] : v[7:0], 8'h00};
  endfunction
  // one bus cycle; for reads d is the expected data
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= w;
    reg_rd_i <= !w;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b0;
    if (!w) begin
      @(negedge clk_i);
      cmp(reg_rdata_o, d);
    end
    @(posedge clk_i);
  endtask
  // write then read back with the strobes back to back
  task wr_rd(input logic [7:0] a, input logic [31:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(negedge clk_i);
    cmp(reg_rdata_o, d);
    @(posedge clk_i);
  endtask
  task cfg(input logic [1:0] f, input logic s, p, i, input logic [2:0] n);
    fmt = f;
    swap = s;
    pol = p;
    sh = n;
    inv = i;
    wr_rd(8'h04, {29'h0, n});
    wr_rd(8'h00, {26'h0, i, p, s, f, 1'b1});
    sen.idle();
  endtask
  task burst(input int k);
    logic [15:0] w;
    repeat (k) begin
      w = 16'($random(seed));
      if (fmt == 2'h0) w = w & (16'hFFFF >> sh);
      q.push_back(exp_w(w));
      sen.send(w);
    end
    sen.stop();
    repeat (40) @(posedge clk_i);
    cmp(q.size(), 0);
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(negedge clk_i);
    cmp(video_pins_o, 1);
    @(posedge clk_i);
    bus(0, 8'h08, 32'h0);
    bus(0, 8'h14, 32'h0);
    for (int n = 0; n < 8; n++) begin
      cfg(2'h0, 1'b0, n[0], n[1], n[2:0]);
      burst(4);
    end
    cfg(2'h1, 1'b0, 1'b0, 1'b1, 3'h0);
    burst(4);
    cfg(2'h2, 1'b1, 1'b1, 1'b0, 3'h0);
    burst(4);
    cfg(2'h2, 1'b0, 1'b0, 1'b0, 3'h0);
    burst(4);
    // nonzero low pin select blocks capture
    bus(1, 8'h08, 32'h1);
    repeat (2) @(negedge clk_i);
    cmp(video_pins_o, 0);
    sen.send(16'h1234);
    sen.stop();
    repeat (20) @(posedge clk_i);
    bus(1, 8'h08, 32'hABCD0000);
    burst(2);
    // stall downstream until the buffer overflows
    chk <= 1'b0;
    hold <= 1'b1;
    repeat (34) sen.send(16'($random(seed)));
    sen.stop();
    repeat (3) @(negedge clk_i);
    cmp(overflow_o, 1);
    hold <= 1'b0;
    repeat (150) @(posedge clk_i);
    // 79 words taken, buffer drained, overflow still flagged
    bus(0, 8'h0C, 32'h004F0003);
    bus(1, 8'h0C, 32'h1);
    repeat (2) @(negedge clk_i);
    cmp(overflow_o, 0);
    bus(0, 8'h0C, 32'h004F0002);
    wrap_up();
  end
endmodule
bind sia_top sia_checker chk (.clk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .pix_data_o, .pix_valid_o, .pix_ready_i, .video_pins_o, .overflow_o);
`default_nettype wire
